// ---- verilog/cpsc_consts.svh ----
// Constants for the clock, power and system control block
//
// Contract
// - Two-bit select picks crystal (0), RC (1) or low-frequency clock (2/3).
// - Read-only flags at bits 7,6,5 report crystal, RC, low-frequency.
// - Crystal-off bit stops crystal at once and keeps it off over wakeup.
// - Bit 3 disables crystal spike filter; resets to zero.
// - Bits 11:8 keep retention RAM banks, one bit per bank.
// - Force boost (bit 7) or buck (bit 6) at wakeup; boost wins.
// - Once a force bit is written, both force bits are locked.
// - Bits 5:4 set bus clock division during memory mirroring.
// - Bit 2 powers down radio logic, bit 1 peripherals; both reset one.
// - Bit 0 requests full hardware reset after wakeup.
// - Writing one to bit 15 resets all but system control register.
// - Power sequencer times out after 2 ms unless bit 9 set.
// - Bit 7 enables debug port; clear frees debug pins as GPIO.
// - Bit 6 drives reset request to one-time memory controller.
// - Bit 5 zero holds pad controls, one makes latch transparent.
// - Bit 4 copies one-time memory to system RAM after wake.
// - Bit 3 selects low-frequency source: RC zero, crystal one.
// - Development mode keeps system domain on and skips copy on wake.
// - Two-bit field maps ROM, one-time memory, system RAM, retention RAM.
// - Crystal-settled flag rises only after more than 2 ms settling.
// - Trim-applied flag reads one when trim equals programmed value; here it reads one only while the crystal is enabled.
`ifndef CPSC_CONSTS_SVH
`define CPSC_CONSTS_SVH
`define CPSC_OFS_CLK 32'h5000000a
`define CPSC_OFS_PMU 32'h50000010
`define CPSC_OFS_SYS 32'h50000012
`define CPSC_CLK_MASK 16'h00ef
`define CPSC_PMU_MASK 16'h0ff7
`define CPSC_SYS_MASK 16'h02ff
`define CPSC_CLK_RST 16'h0000
`define CPSC_PMU_RST 16'h0006
`define CPSC_SYS_RST 16'h0020
`define CPSC_CLK_XTAL_BIT 7
`define CPSC_CLK_RC_BIT 6
`define CPSC_CLK_LF_BIT 5
`define CPSC_CLK_SPIKE_BIT 3
`define CPSC_CLK_OFF_BIT 2
`define CPSC_PMU_BOOST_BIT 7
`define CPSC_PMU_BUCK_BIT 6
`define CPSC_PMU_RADIO_BIT 2
`define CPSC_PMU_PERIPH_BIT 1
`define CPSC_PMU_RSTWAKE_BIT 0
`define CPSC_SYS_SWRST_BIT 15
`define CPSC_SYS_TODIS_BIT 9
`define CPSC_SYS_DBG_BIT 7
`define CPSC_SYS_OTPRST_BIT 6
`define CPSC_SYS_PAD_BIT 5
`define CPSC_SYS_COPY_BIT 4
`define CPSC_SYS_LFSRC_BIT 3
`define CPSC_SYS_DEV_BIT 2
`define CPSC_CLK_PERIOD_NS 8
`define CPSC_SETTLE_NS 2000000
`define CPSC_TIMEOUT_NS 2000000
`endif

// ---- verilog/cpsc_pkg.sv ----
// Types for the clock, power and system control block
package cpsc_pkg;
   typedef enum logic [1:0] {CPSC_SRC_XTAL, CPSC_SRC_RC, CPSC_SRC_LF} cpsc_src_t;
   typedef enum logic [1:0] {CPSC_MAP_ROM, CPSC_MAP_OTP, CPSC_MAP_SYSTEM_RAM,
      CPSC_MAP_RETENTION_RAM} cpsc_map_t;
   typedef enum logic {CPSC_AWAKE, CPSC_ASLEEP} cpsc_pwr_t;
endpackage

// ---- verilog/cpsc_ctrl.sv ----
// Clock source, power management and system control registers
`timescale 1ns/1ps
`include "cpsc_consts.svh"
module cpsc_ctrl #(
   parameter int unsigned SETTLE_CYC =
      `CPSC_SETTLE_NS / `CPSC_CLK_PERIOD_NS + 1,
   parameter int unsigned TIMEOUT_CYC =
      `CPSC_TIMEOUT_NS / `CPSC_CLK_PERIOD_NS
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [31:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata,
   input wire logic sleep_pin,
   input wire logic trim_match_pin,
   input wire logic pwr_busy_pin,
   output logic hf_crystal_en,
   output logic hf_spike_filter_off,
   output logic hf_crystal_settled,
   output logic hf_trim_applied,
   output cpsc_pkg::cpsc_src_t sys_clk_src,
   output logic [3:0] keep_ram_banks,
   output logic dcdc_boost,
   output logic dcdc_buck,
   output logic [1:0] mirror_clk_div,
   output logic radio_powerdown,
   output logic peripheral_powerdown,
   output logic wake_hw_reset,
   output logic software_device_reset,
   output logic pwr_seq_timeout,
   output logic debug_enable,
   output logic debug_pins_gpio,
   output logic one_time_memory_ctrl_reset_request,
   output logic pad_latch_transparent,
   output logic otp_copy_start,
   output logic low_freq_source_select,
   output logic system_power_domain_gate,
   output cpsc_pkg::cpsc_map_t boot_address_map_select
);
   import cpsc_pkg::*;

   // ********************************************
   // Helpers
   // ********************************************
   // Saturating count up while run holds, clear otherwise
   function automatic logic [17:0] count_step(input logic [17:0] c,
      input logic run, input logic [17:0] lim);
      if (!run)
         count_step = 18'h00000;
      else if (c < lim)
         count_step = c + 18'h00001;
      else
         count_step = c;
   endfunction

   localparam logic [17:0] SETTLE_LIM = SETTLE_CYC[17:0];
   localparam logic [17:0] TIMEOUT_LIM = TIMEOUT_CYC[17:0];

   // ********************************************
   // Pin synchronisers
   // ********************************************
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic sleep_d_reg;
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
         sleep_d_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= {sleep_pin, trim_match_pin, pwr_busy_pin};
         sync_reg <= meta_reg;
         sleep_d_reg <= sync_reg[2];
      end
   end
   wire sleep_s = sync_reg[2];
   wire trim_s = sync_reg[1];
   wire busy_s = sync_reg[0];
   wire wake_evt = sleep_d_reg & ~sleep_s;

   // ********************************************
   // Register decode
   // ********************************************
   logic [15:0] clk_reg;
   logic [15:0] pmu_reg;
   logic [15:0] sys_reg;
   logic lock_reg;
   logic swrst_reg;
   wire blk_rst = ~nrst | swrst_reg;
   wire wr_clk = wr_stb & (addr == `CPSC_OFS_CLK);
   wire wr_pmu = wr_stb & (addr == `CPSC_OFS_PMU);
   wire wr_sys = wr_stb & (addr == `CPSC_OFS_SYS);
   wire [15:0] force_mask = 16'h00c0;
   wire [15:0] pmu_wmask = lock_reg ? (`CPSC_PMU_MASK & ~force_mask)
      : `CPSC_PMU_MASK;
   wire [15:0] clk_next = (wdata & `CPSC_CLK_MASK & 16'h000f);
   wire [15:0] pmu_next = (pmu_reg & ~pmu_wmask) | (wdata & pmu_wmask);
   wire [15:0] sys_next = wdata & `CPSC_SYS_MASK;

   // ********************************************
   // Registers
   // ********************************************
   // software reset spares system control register
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         sys_reg <= `CPSC_SYS_RST;
      else if (wr_sys)
         sys_reg <= sys_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         swrst_reg <= 1'b0;
      else
         swrst_reg <= wr_sys & wdata[`CPSC_SYS_SWRST_BIT];
   end

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         clk_reg <= `CPSC_CLK_RST;
      else if (wr_clk)
         clk_reg <= clk_next;
   end

   // lock after any write carrying a force bit
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         pmu_reg <= `CPSC_PMU_RST;
         lock_reg <= 1'b0;
      end
      else if (wr_pmu)
      begin
         pmu_reg <= pmu_next;
         lock_reg <= lock_reg | (|(wdata & force_mask));
      end
   end

   // ********************************************
   // Clock source tracking
   // ********************************************
   // crystal off at once and held over wakeup
   assign hf_crystal_en = ~clk_reg[`CPSC_CLK_OFF_BIT];
   assign hf_spike_filter_off = clk_reg[`CPSC_CLK_SPIKE_BIT];

   logic [17:0] settle_reg;
   // settled after more than 2 ms of crystal running
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         settle_reg <= 18'h00000;
      else
         settle_reg <= count_step(settle_reg, hf_crystal_en, SETTLE_LIM);
   end
   assign hf_crystal_settled = (settle_reg == SETTLE_LIM);
   // trim comparison arrives from the trim logic
   assign hf_trim_applied = trim_s & hf_crystal_en;
   wire xtal_ok = hf_crystal_settled | hf_trim_applied;

   // source follows select; crystal only once usable
   wire [1:0] sel = clk_reg[1:0];
   cpsc_src_t src_reg;
   cpsc_src_t src_next;
   always_comb
   begin
      src_next = src_reg;
      case (sel)
         2'h0:
            if (xtal_ok)
               src_next = CPSC_SRC_XTAL;
         2'h1:
            src_next = CPSC_SRC_RC;
         default:
            src_next = CPSC_SRC_LF;
      endcase
   end
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         src_reg <= CPSC_SRC_XTAL;
      else
         src_reg <= src_next;
   end
   assign sys_clk_src = src_reg;
   wire [2:0] run_flags = {src_reg == CPSC_SRC_XTAL, src_reg == CPSC_SRC_RC,
      src_reg == CPSC_SRC_LF};

   // ********************************************
   // Power management
   // ********************************************
   // retention bank keep bits
   assign keep_ram_banks = pmu_reg[11:8];
   assign mirror_clk_div = pmu_reg[5:4];
   assign radio_powerdown = pmu_reg[`CPSC_PMU_RADIO_BIT];
   assign peripheral_powerdown = pmu_reg[`CPSC_PMU_PERIPH_BIT];

   cpsc_pwr_t pwr_reg;
   logic boost_reg;
   logic buck_reg;
   logic wake_rst_reg;
   logic copy_reg;
   wire boost_req = pmu_reg[`CPSC_PMU_BOOST_BIT];
   wire buck_req = pmu_reg[`CPSC_PMU_BUCK_BIT];
   wire dev_mode = sys_reg[`CPSC_SYS_DEV_BIT];
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
         pwr_reg <= CPSC_AWAKE;
      else
         case (pwr_reg)
            CPSC_AWAKE:
               if (sleep_s)
                  pwr_reg <= CPSC_ASLEEP;
            CPSC_ASLEEP:
               if (!sleep_s)
                  pwr_reg <= CPSC_AWAKE;
            default:
               pwr_reg <= CPSC_AWAKE;
         endcase
   end

   // boost wins over buck, applied at wakeup
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         boost_reg <= 1'b0;
         buck_reg <= 1'b0;
      end
      else if (wake_evt)
      begin
         boost_reg <= boost_req;
         buck_reg <= buck_req & ~boost_req;
      end
   end
   assign dcdc_boost = boost_reg;
   assign dcdc_buck = buck_reg;

   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         wake_rst_reg <= 1'b0;
         copy_reg <= 1'b0;
      end
      else
      begin
         wake_rst_reg <= wake_evt & pmu_reg[`CPSC_PMU_RSTWAKE_BIT];
         // copy on wake; skipped in development mode
         copy_reg <= wake_evt & sys_reg[`CPSC_SYS_COPY_BIT] & ~dev_mode;
      end
   end
   assign wake_hw_reset = wake_rst_reg;
   assign otp_copy_start = copy_reg;
   // system domain never gated in development mode
   assign system_power_domain_gate = (pwr_reg == CPSC_ASLEEP) & ~dev_mode;

   // ********************************************
   // Power sequencer timeout
   // ********************************************
   logic [17:0] to_cnt_reg;
   logic to_reg;
   wire to_dis = sys_reg[`CPSC_SYS_TODIS_BIT];
   // give up waiting after 2 ms unless disabled
   always_ff @(posedge clk_sys)
   begin
      if (blk_rst)
      begin
         to_cnt_reg <= 18'h00000;
         to_reg <= 1'b0;
      end
      else
      begin
         to_cnt_reg <= count_step(to_cnt_reg, busy_s & ~to_dis, TIMEOUT_LIM);
         to_reg <= (to_cnt_reg == TIMEOUT_LIM - 18'h00001) & busy_s & ~to_dis;
      end
   end
   assign pwr_seq_timeout = to_reg;

   // ********************************************
   // System control outputs
   // ********************************************
   assign software_device_reset = swrst_reg;
   assign debug_enable = sys_reg[`CPSC_SYS_DBG_BIT];
   assign debug_pins_gpio = ~sys_reg[`CPSC_SYS_DBG_BIT];
   assign one_time_memory_ctrl_reset_request = sys_reg[`CPSC_SYS_OTPRST_BIT];
   assign pad_latch_transparent = sys_reg[`CPSC_SYS_PAD_BIT];
   assign low_freq_source_select = sys_reg[`CPSC_SYS_LFSRC_BIT];
   assign boot_address_map_select = cpsc_map_t'(sys_reg[1:0]);

   // ********************************************
   // Read port
   // ********************************************
   // Write-only reset bit never reads back
   wire [15:0] clk_view = {8'h00, run_flags, 1'b0, clk_reg[3:0]};
   wire [15:0] rd_mux = (addr == `CPSC_OFS_CLK) ? clk_view :
      (addr == `CPSC_OFS_PMU) ? pmu_reg :
      (addr == `CPSC_OFS_SYS) ? sys_reg : 16'h0000;
   logic [15:0] rdata_reg;
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         rdata_reg <= 16'h0000;
      else if (rd_stb)
         rdata_reg <= rd_mux;
      else
         rdata_reg <= 16'h0000;
   end
   assign rdata = rdata_reg;

   // ********************************************
   // Assertions
   // ********************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_wake_boost;
      wake_evt && boost_req;
   endsequence
   sequence s_xtal_restart;
      !hf_crystal_en ##1 hf_crystal_en;
   endsequence

   a_clk_sel_rc: assert property (
      (sel == 2'h1) && !swrst_reg |=> src_reg == CPSC_SRC_RC)
      else $error("rc select not followed");
   a_run_flags: assert property (
      $onehot(run_flags)) else $error("running flags not one-hot");
   a_xtal_off_now: assert property (
      wr_clk && wdata[`CPSC_CLK_OFF_BIT] |=> !hf_crystal_en)
      else $error("crystal not stopped");
   a_settle_min: assert property (
      s_xtal_restart |-> !hf_crystal_settled [*2])
      else $error("settled too early");
   a_boost_prio: assert property (
      (s_wake_boost and !swrst_reg) |=> dcdc_boost && !dcdc_buck)
      else $error("boost priority lost");
   a_force_lock: assert property (
      lock_reg && wr_pmu && !swrst_reg |=> $stable(pmu_reg[7:6]))
      else $error("force bits changed while locked");
   a_swrst_keep: assert property (
      swrst_reg && !wr_sys |=> $stable(sys_reg) && pmu_reg == `CPSC_PMU_RST)
      else $error("software reset scope wrong");
   a_timeout_dis: assert property (
      pwr_seq_timeout |-> $past(!to_dis)) else $error("timeout while off");
   a_dev_nocopy: assert property (
      otp_copy_start |-> $past(!dev_mode)) else $error("copy in dev mode");
   a_wake_reset: assert property (
      wake_evt && pmu_reg[0] && !swrst_reg |=> wake_hw_reset)
      else $error("no reset after wake");
   a_reserved_zero: assert property (
      rd_stb && addr == `CPSC_OFS_CLK |=> rdata[15:8] == 8'h00 && !rdata[4])
      else $error("reserved bits nonzero");
endmodule

// ---- verification/clock_power_system_control_tb_top.sv ----
// Self-checking bench for the clock, power and system control registers
`timescale 1ns/1ps
`include "cpsc_consts.svh"
module clock_power_system_control_tb_top;
   import cpsc_pkg::*;
   localparam logic [31:0] A_CLK = `CPSC_OFS_CLK;
   localparam logic [31:0] A_PMU = `CPSC_OFS_PMU;
   localparam logic [31:0] A_SYS = `CPSC_OFS_SYS;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [15:0] wdata = 16'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic sleep_pin = 1'b0;
   logic trim_match_pin = 1'b0;
   logic pwr_busy_pin = 1'b0;
   logic [15:0] rdata;
   logic hf_crystal_en, hf_spike_filter_off, hf_crystal_settled;
   logic hf_trim_applied, dcdc_boost, dcdc_buck, radio_powerdown;
   logic peripheral_powerdown, wake_hw_reset, software_device_reset;
   logic pwr_seq_timeout, debug_enable, debug_pins_gpio;
   logic one_time_memory_ctrl_reset_request, pad_latch_transparent;
   logic otp_copy_start, low_freq_source_select, system_power_domain_gate;
   logic [3:0] keep_ram_banks;
   logic [1:0] mirror_clk_div;
   cpsc_src_t sys_clk_src;
   cpsc_map_t boot_address_map_select;
   int fail_count = 0;
   int num_checks = 0;
   int wake_cnt = 0;
   int copy_cnt = 0;
   int swr_cnt = 0;
   int to_cnt = 0;
   integer seed = 32'h16b0047b;
   logic [15:0] v;

   // ****************************************
   // Design and clock
   // ****************************************
   // Short counts keep the run small
   cpsc_ctrl #(.SETTLE_CYC(20), .TIMEOUT_CYC(16)) dut (.clk_sys, .nrst,
      .addr, .wdata, .wr_stb, .rd_stb, .rdata, .sleep_pin,
      .trim_match_pin, .pwr_busy_pin, .hf_crystal_en, .hf_spike_filter_off,
      .hf_crystal_settled, .hf_trim_applied, .sys_clk_src, .keep_ram_banks,
      .dcdc_boost, .dcdc_buck, .mirror_clk_div, .radio_powerdown,
      .peripheral_powerdown, .wake_hw_reset, .software_device_reset,
      .pwr_seq_timeout, .debug_enable, .debug_pins_gpio,
      .one_time_memory_ctrl_reset_request, .pad_latch_transparent,
      .otp_copy_start, .low_freq_source_select, .system_power_domain_gate,
      .boot_address_map_select);

   always #4 clk_sys = ~clk_sys;

   // Pulse counters; a stretched pulse shows up as an extra count
   always @(posedge clk_sys)
   begin
      if (nrst)
      begin
         wake_cnt <= wake_cnt + int'(wake_hw_reset);
         copy_cnt <= copy_cnt + int'(otp_copy_start);
         swr_cnt <= swr_cnt + int'(software_device_reset);
         to_cnt <= to_cnt + int'(pwr_seq_timeout);
      end
   end

   // ****************************************
   // Tasks and expectation functions
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Flags follow the source, control bits read back as written
   function automatic logic [15:0] clk_rd(input logic [3:0] ctl);
      logic [2:0] f;
      f = (ctl[1:0] == 2'h0) ? 3'b100 : (ctl[1:0] == 2'h1) ? 3'b010 : 3'b001;
      return {8'h00, f, 1'b0, ctl};
   endfunction

   task automatic print_verdict;
      if (fail_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      print_verdict;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      rdc(A_CLK, 16'h0080);
      rdc(A_PMU, 16'h0006);
      rdc(A_SYS, 16'h0020);
      wr(32'h50000014, 16'hffff);
      rdc(32'h50000014, 16'h0000);
      rdc(A_PMU, 16'h0006);
      // Force bits left out so the lock stays open here
      repeat (8)
      begin
         v = 16'($random(seed));
         wr(A_PMU, v & 16'hff3f);
         rdc(A_PMU, v & 16'h0f37);
         chk({v[11:8], v[5:4], v[2:1]}, {8'h0, keep_ram_banks, mirror_clk_div,
            radio_powerdown, peripheral_powerdown});
         wr(A_SYS, v & 16'h7fff);
         rdc(A_SYS, v & 16'h02ff);
         chk({8'h0, v[7:5], v[3], v[1:0]}, {8'h0, debug_enable,
            one_time_memory_ctrl_reset_request, pad_latch_transparent,
            low_freq_source_select, boot_address_map_select});
         chk(16'(debug_pins_gpio), {15'h0000, ~v[7]});
      end
      for (int s = 1; s < 4; s++)
      begin
         wr(A_CLK, 16'(s));
         w(3);
         chk(16'(sys_clk_src), (s == 1) ? 16'h1 : 16'h2);
         rdc(A_CLK, clk_rd(4'(s)));
      end
      wr(A_CLK, 16'h000b);
      w(2);
      chk(16'(hf_spike_filter_off), 16'h1);
      rdc(A_CLK, 16'h002b);
      // crystal stopped while running on the low-frequency clock
      wr(A_CLK, 16'h0006);
      w(3);
      chk({hf_crystal_en, hf_crystal_settled}, 16'h0);
      // Crystal restarted on the slow source first
      wr(A_CLK, 16'h0002);
      w(5);
      chk({hf_crystal_settled, 1'b0, sys_clk_src}, 16'h2);
      w(30);
      chk(16'(hf_crystal_settled), 16'h1);
      wr(A_CLK, 16'h0000);
      w(3);
      chk(16'(sys_clk_src), 16'h0);
      rdc(A_CLK, 16'h0080);
      trim_match_pin <= 1'b1;
      w(5);
      chk(16'(hf_trim_applied), 16'h1);
      // Random writes may have left the timeout disabled
      wr(A_SYS, 16'h0020);
      pwr_busy_pin <= 1'b1;
      w(24);
      pwr_busy_pin <= 1'b0;
      w(4);
      chk(16'(to_cnt), 16'h1);
      wr(A_SYS, 16'h0200);
      pwr_busy_pin <= 1'b1;
      w(24);
      pwr_busy_pin <= 1'b0;
      w(4);
      chk(16'(to_cnt), 16'h1);
      // Both force bits at once, then a wake
      wr(A_PMU, 16'h00c1);
      wr(A_SYS, 16'h0010);
      w(2);
      chk(16'(system_power_domain_gate), 16'h0);
      sleep_pin <= 1'b1;
      w(5);
      chk(16'(system_power_domain_gate), 16'h1);
      sleep_pin <= 1'b0;
      w(8);
      chk({dcdc_boost, dcdc_buck}, 16'h2);
      chk(16'(wake_cnt), 16'h1);
      chk(16'(copy_cnt), 16'h1);
      // Development mode: domain stays powered, no copy on wake
      wr(A_SYS, 16'h0014);
      sleep_pin <= 1'b1;
      w(5);
      chk(16'(system_power_domain_gate), 16'h0);
      sleep_pin <= 1'b0;
      w(8);
      chk(16'(copy_cnt), 16'h1);
      chk(16'(wake_cnt), 16'h2);
      wr(A_PMU, 16'h0040);
      rdc(A_PMU, 16'h00c0);
      // Software reset keeps the system register only
      wr(A_SYS, 16'h80b5);
      w(3);
      chk(16'(swr_cnt), 16'h1);
      rdc(A_SYS, 16'h00b5);
      rdc(A_PMU, 16'h0006);
      rdc(A_CLK, 16'h0080);
      chk({dcdc_boost, dcdc_buck}, 16'h0);
      wr(A_PMU, 16'h0040);
      rdc(A_PMU, 16'h0040);
      print_verdict;
   end
endmodule
